// ### src/clk_ctrl_pkg.sv
package clk_ctrl_pkg;
    // nominal source frequencies, for reference by software models
    localparam int FAST_XTAL_MIN_HZ = 3_000_000;
    localparam int FAST_XTAL_MAX_HZ = 25_000_000;
    localparam int BYPASS_MIN_HZ = 1_000_000;
    localparam int BYPASS_MAX_HZ = 50_000_000;
    localparam int SLOW_XTAL_MHZ_X1000 = 32768;
    localparam int SLOW_RC_HZ = 40_000;

    // register byte offsets
    localparam logic [7:0] OFS_CLOCK_CONTROL = 8'h00;
    localparam logic [7:0] OFS_CLOCK_CONFIG = 8'h04;
    localparam logic [7:0] OFS_BACKUP_CTL = 8'h08;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h0c;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
    localparam logic [7:0] OFS_BOOT_STATUS = 8'h14;

    // clock_control_reg fields
    localparam int CTL_XTAL_EN = 0;
    localparam int CTL_RC_EN = 1;
    localparam int CTL_BYPASS = 2;
    localparam int CTL_MON_EN = 3;
    localparam int CTL_PLL_EN = 4;
    localparam int CTL_PLL_SRC = 5;
    localparam int CTL_SYS_LO = 6;
    localparam int CTL_XTAL_OK = 8;
    // clock_config_reg fields
    localparam int CFG_OUT_LO = 0;
    localparam int CFG_PLL_DIV2 = 3;
    // backup_domain_ctl_reg fields
    localparam int BDC_SLOW_XTAL_EN = 0;
    localparam int BDC_SLOW_BYPASS = 1;
    localparam int BDC_SLOW_RC_EN = 2;
    // clock_irq_reg fields
    localparam int IRQ_FAULT = 0;
    localparam int IRQ_PLL_OFF = 1;
    localparam int IRQ_W = 2;
    // boot option bit inside user_option_byte
    localparam int OPT_BOOT_N = 4;

    // reset values
    localparam logic [31:0] CTL_RESET = 32'h0000_0002;
    localparam logic [2:0] OUT_SEL_RESET = 3'h0;
    localparam logic [2:0] BOOT_SETTLE_CYCLES = 3'h3;

    typedef enum logic [1:0] {
        SYS_FAST_RC = 2'h0,
        SYS_FAST_XTAL = 2'h1,
        SYS_PLL = 2'h2
    } sys_src_t;

    typedef enum logic [2:0] {
        OUT_NONE = 3'h0,
        OUT_ADC_RC = 3'h1,
        OUT_SLOW_RC = 3'h2,
        OUT_SLOW_XTAL = 3'h3,
        OUT_SYSTEM = 3'h4,
        OUT_FAST_RC = 3'h5,
        OUT_FAST_XTAL = 3'h6,
        OUT_PLL = 3'h7
    } out_sel_t;

    typedef enum logic [1:0] {
        BOOT_MAIN_FLASH = 2'h0,
        BOOT_SYSTEM_MEM = 2'h1,
        BOOT_SRAM = 2'h3
    } boot_t;
endpackage

// ### src/clock_source_ctrl.sv
// Operation
// (R01) four sources: fast/slow crystal, fast/slow RC
// (R02) pll input picks fast crystal or fast RC
// (R03) fast bypass takes external clock on input
// (R04) slow bypass takes external clock on input
// (R05) three-bit field picks clock output source
// (R06) output codes 0-7 in listed ascending order
// (R07) software enables monitor only after crystal start
// (R08) monitored crystal failure disables fast crystal
// (R09) failure sets monitor fault flag
// (R10) fault event drives non-maskable interrupt
// (R11) failed crystal as system clock: use fast RC
// (R12) failed crystal feeding pll: disable pll
// (R13) software reconfigures rtc clock after failure
// (R14) boot pin and bit choose flash/system/sram
// (R15) boot bit is inverse of option bit four
// (R16) boot choice sampled only at reset
//
// The register offsets and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module clock_source_ctrl (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic fast_xtal_ok_i,
    input wire logic boot_select_pin_i,
    input wire logic [7:0] user_option_byte_i,
    output logic fast_xtal_en_o,
    output logic fast_rc_en_o,
    output logic fast_osc_bypass_o,
    output logic slow_xtal_en_o,
    output logic slow_rc_en_o,
    output logic slow_osc_bypass_o,
    output logic pll_en_o,
    output logic pll_src_xtal_o,
    output clk_ctrl_pkg::sys_src_t system_clock_sel_o,
    output clk_ctrl_pkg::out_sel_t clock_out_select_o,
    output logic pll_out_div2_o,
    output clk_ctrl_pkg::boot_t boot_mode_o,
    output logic irq_o,
    output logic nmi_o
);
    import clk_ctrl_pkg::*;

    logic [31:0] ctl_ff;
    logic [3:0] cfg_ff;
    logic [2:0] bdc_ff;
    logic [IRQ_W-1:0] status_ff;
    logic [IRQ_W-1:0] mask_ff;
    logic ok_meta_ff;
    logic ok_sync_ff;
    logic pin_meta_ff;
    logic pin_sync_ff;
    logic [2:0] settle_ff;
    logic boot_taken_ff;
    boot_t boot_ff;
    logic ack_ff;
    logic [31:0] rdata_ff;
    logic irq_ff;
    logic nmi_ff;

    // bus decode
    wire req = wb_cyc_i && wb_stb_i && !ack_ff;
    wire wr = req && wb_we_i;
    wire wr_ctl = wr && (wb_adr_i == OFS_CLOCK_CONTROL);
    wire wr_cfg = wr && (wb_adr_i == OFS_CLOCK_CONFIG);
    wire wr_bdc = wr && (wb_adr_i == OFS_BACKUP_CTL);
    wire wr_sts = wr && (wb_adr_i == OFS_IRQ_STATUS);
    wire wr_msk = wr && (wb_adr_i == OFS_IRQ_MASK);

    // merge write data under byte enables
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
            input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // failure detect: only while monitor and crystal are both on
    wire fault_now = ctl_ff[CTL_MON_EN] && ctl_ff[CTL_XTAL_EN] && !ok_sync_ff; // R08 R07
    wire sys_on_xtal = (ctl_ff[CTL_SYS_LO +: 2] == SYS_FAST_XTAL);
    wire pll_on_xtal = ctl_ff[CTL_PLL_EN] && ctl_ff[CTL_PLL_SRC];
    wire sys_on_xpll = (ctl_ff[CTL_SYS_LO +: 2] == SYS_PLL) && pll_on_xtal;

    wire [31:0] ctl_wr = wr_ctl ? merge(ctl_ff, wb_dat_i, wb_sel_i) : ctl_ff;
    wire [31:0] cfg_wr = merge({28'h0, cfg_ff}, wb_dat_i, wb_sel_i);
    wire [31:0] bdc_wr = merge({29'h0, bdc_ff}, wb_dat_i, wb_sel_i);
    wire [31:0] msk_wr = merge({30'h0, mask_ff}, wb_dat_i, wb_sel_i);
    wire [IRQ_W-1:0] w1c = (wr_sts && wb_sel_i[0]) ? wb_dat_i[IRQ_W-1:0] : {IRQ_W{1'b0}};

    // fault overrides software write in the same cycle
    logic [31:0] nxt_ctl;
    always_comb begin
        nxt_ctl = ctl_wr;
        nxt_ctl[31:8] = 24'h0;
        if (fault_now) begin
            nxt_ctl[CTL_XTAL_EN] = 1'b0; // R08
            nxt_ctl[CTL_MON_EN] = 1'b0;
            if (pll_on_xtal) begin
                nxt_ctl[CTL_PLL_EN] = 1'b0; // R12
            end
            if (sys_on_xtal || sys_on_xpll) begin
                nxt_ctl[CTL_SYS_LO +: 2] = SYS_FAST_RC; // R11
                nxt_ctl[CTL_RC_EN] = 1'b1;
            end
        end
        if (nxt_ctl[CTL_SYS_LO +: 2] == 2'h3) begin
            nxt_ctl[CTL_SYS_LO +: 2] = ctl_ff[CTL_SYS_LO +: 2];
        end
    end

    // set wins over clear on the sticky flags
    wire [IRQ_W-1:0] events = {fault_now && pll_on_xtal, fault_now};
    wire [IRQ_W-1:0] nxt_status = (status_ff & ~w1c) | events; // R09

    // read mux, unmapped offsets read zero
    logic [31:0] nxt_rdata;
    always_comb begin
        nxt_rdata = 32'h0;
        unique case (wb_adr_i)
            OFS_CLOCK_CONTROL: nxt_rdata = {23'h0, ok_sync_ff, ctl_ff[7:0]};
            OFS_CLOCK_CONFIG: nxt_rdata = {28'h0, cfg_ff};
            OFS_BACKUP_CTL: nxt_rdata = {29'h0, bdc_ff};
            OFS_IRQ_STATUS: nxt_rdata = {30'h0, status_ff};
            OFS_IRQ_MASK: nxt_rdata = {30'h0, mask_ff};
            OFS_BOOT_STATUS: nxt_rdata = {30'h0, boot_ff};
            default: nxt_rdata = 32'h0;
        endcase
    end

    // boot target from synced pin and inverted option bit
    wire boot_bit = !user_option_byte_i[OPT_BOOT_N]; // R15
    wire [1:0] nxt_boot = !pin_sync_ff ? BOOT_MAIN_FLASH :
        (boot_bit ? BOOT_SRAM : BOOT_SYSTEM_MEM); // R14

    // synchronisers, no reset so the pin is seen right after release
    always_ff @(posedge clk_i) begin
        ok_meta_ff <= fast_xtal_ok_i;
        ok_sync_ff <= ok_meta_ff;
        pin_meta_ff <= boot_select_pin_i;
        pin_sync_ff <= pin_meta_ff;
    end

    // control registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_ff <= CTL_RESET;
            cfg_ff <= {1'b0, OUT_SEL_RESET};
            bdc_ff <= 3'h0;
            mask_ff <= {IRQ_W{1'b0}};
            status_ff <= {IRQ_W{1'b0}};
        end else begin
            ctl_ff <= nxt_ctl;
            if (wr_cfg) begin
                cfg_ff <= cfg_wr[3:0]; // R05
            end
            if (wr_bdc) begin
                bdc_ff <= bdc_wr[2:0]; // R04
            end
            if (wr_msk) begin
                mask_ff <= msk_wr[IRQ_W-1:0];
            end
            status_ff <= nxt_status;
        end
    end

    // boot latch: wait for synchroniser to fill, then hold until reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            settle_ff <= 3'h0;
            boot_taken_ff <= 1'b0;
            boot_ff <= BOOT_MAIN_FLASH;
        end else if (!boot_taken_ff) begin
            settle_ff <= settle_ff + 3'h1;
            if (settle_ff == BOOT_SETTLE_CYCLES) begin
                boot_taken_ff <= 1'b1; // R16
                boot_ff <= boot_t'(nxt_boot);
            end
        end
    end

    // bus answer one cycle after request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            rdata_ff <= 32'h0;
        end else begin
            ack_ff <= req;
            rdata_ff <= req ? nxt_rdata : 32'h0;
        end
    end

    // interrupt lines; nmi ignores the mask by design
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_ff <= 1'b0;
            nmi_ff <= 1'b0;
        end else begin
            irq_ff <= |(nxt_status & mask_ff);
            nmi_ff <= nxt_status[IRQ_FAULT]; // R10
        end
    end

    // outputs, all flip-flop driven
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdata_ff;
    assign fast_xtal_en_o = ctl_ff[CTL_XTAL_EN]; // R01
    assign fast_rc_en_o = ctl_ff[CTL_RC_EN];
    assign fast_osc_bypass_o = ctl_ff[CTL_BYPASS]; // R03
    assign slow_xtal_en_o = bdc_ff[BDC_SLOW_XTAL_EN];
    assign slow_rc_en_o = bdc_ff[BDC_SLOW_RC_EN];
    assign slow_osc_bypass_o = bdc_ff[BDC_SLOW_BYPASS];
    assign pll_en_o = ctl_ff[CTL_PLL_EN];
    assign pll_src_xtal_o = ctl_ff[CTL_PLL_SRC]; // R02
    assign system_clock_sel_o = sys_src_t'(ctl_ff[CTL_SYS_LO +: 2]);
    assign clock_out_select_o = out_sel_t'(cfg_ff[CFG_OUT_LO +: 3]); // R06
    assign pll_out_div2_o = cfg_ff[CFG_PLL_DIV2];
    assign boot_mode_o = boot_ff;
    assign irq_o = irq_ff;
    assign nmi_o = nmi_ff;

    // checks
    fault_kills_xtal_a: assert property (@(posedge clk_i) disable iff (rst_i) // R08
        fault_now |=> !fast_xtal_en_o)
        else $error("crystal still enabled after fault");
    fault_sets_flag_a: assert property (@(posedge clk_i) disable iff (rst_i) // R09
        fault_now |=> status_ff[IRQ_FAULT])
        else $error("fault flag not set");
    fault_nmi_a: assert property (@(posedge clk_i) disable iff (rst_i) // R10
        fault_now |=> nmi_o)
        else $error("nmi not raised on fault");
    sys_fallback_a: assert property (@(posedge clk_i) disable iff (rst_i) // R11
        (fault_now && sys_on_xtal) |=> system_clock_sel_o == SYS_FAST_RC && fast_rc_en_o)
        else $error("system clock not moved to fast rc");
    pll_shutdown_a: assert property (@(posedge clk_i) disable iff (rst_i) // R12
        (fault_now && pll_on_xtal) |=> !pll_en_o ##0 status_ff[IRQ_PLL_OFF])
        else $error("pll not disabled on fault");
    boot_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // R16
        boot_taken_ff |=> $stable(boot_mode_o))
        else $error("boot mode changed while running");
    boot_flash_a: assert property (@(posedge clk_i) disable iff (rst_i) // R14
        (!boot_taken_ff && settle_ff == BOOT_SETTLE_CYCLES && !pin_sync_ff)
        |=> boot_mode_o == BOOT_MAIN_FLASH)
        else $error("pin low must boot main flash");
    boot_option_a: assert property (@(posedge clk_i) disable iff (rst_i) // R15
        (!boot_taken_ff && settle_ff == BOOT_SETTLE_CYCLES && pin_sync_ff
        && user_option_byte_i[OPT_BOOT_N]) |=> boot_mode_o == BOOT_SYSTEM_MEM)
        else $error("option one must boot system memory");
    boot_sram_a: assert property (@(posedge clk_i) disable iff (rst_i) // R14
        (!boot_taken_ff && settle_ff == BOOT_SETTLE_CYCLES && pin_sync_ff
        && !user_option_byte_i[OPT_BOOT_N]) |=> boot_mode_o == BOOT_SRAM)
        else $error("option zero with pin high must boot sram");
    out_sel_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // R05
        (wr_cfg && wb_sel_i[0]) |=> clock_out_select_o == $past(wb_dat_i[2:0]))
        else $error("clock output select not written");
    bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
        req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single cycle after request");

    // register side: reserved code ignored, idle bus reads zero, irq tracks mask
    sys_sel_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_ctl && wb_sel_i[0] && wb_dat_i[CTL_SYS_LO +: 2] == 2'h3 && !fault_now)
        |=> $stable(system_clock_sel_o))
        else $error("reserved system source code was taken");
    read_idle_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_o == |(status_ff & $past(mask_ff)))
        else $error("irq does not follow masked status");

    // sticky flag and unmaskable nmi
    flag_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i) // R09
        (status_ff[IRQ_FAULT] && !w1c[IRQ_FAULT]) |=> status_ff[IRQ_FAULT])
        else $error("fault flag lost without a clear");
    flag_clear_a: assert property (@(posedge clk_i) disable iff (rst_i) // R09
        (w1c[IRQ_FAULT] && !fault_now) |=> !status_ff[IRQ_FAULT])
        else $error("fault flag not cleared by write of one");
    nmi_unmasked_a: assert property (@(posedge clk_i) disable iff (rst_i) // R10
        (status_ff[IRQ_FAULT] && !mask_ff[IRQ_FAULT] && !w1c[IRQ_FAULT]) |=> nmi_o)
        else $error("nmi blocked by the mask");

    // side effects of a failure beyond the crystal itself, and crystal enable held while the monitor is off
    xpll_fallback_a: assert property (@(posedge clk_i) disable iff (rst_i) // R11
        (fault_now && sys_on_xpll) |=> system_clock_sel_o == SYS_FAST_RC && fast_rc_en_o)
        else $error("system on crystal pll not moved to fast rc");
    pll_kept_a: assert property (@(posedge clk_i) disable iff (rst_i) // R12
        (fault_now && !ctl_ff[CTL_PLL_SRC] && !wr_ctl) |=> $stable(pll_en_o))
        else $error("pll on fast rc disabled by crystal fault");
    mon_off_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // R08
        (!ctl_ff[CTL_MON_EN] && !wr_ctl) |=> $stable(fast_xtal_en_o))
        else $error("crystal enable moved with monitor off");
endmodule // clock_source_ctrl
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import clk_ctrl_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic fast_xtal_ok_i = 1'b1;
    logic boot_select_pin_i = 1'b0;
    logic [7:0] user_option_byte_i = 8'h00;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, fast_xtal_en_o, fast_rc_en_o, fast_osc_bypass_o, slow_xtal_en_o;
    logic slow_rc_en_o, slow_osc_bypass_o, pll_en_o, pll_src_xtal_o, pll_out_div2_o, irq_o, nmi_o;
    sys_src_t system_clock_sel_o;
    out_sel_t clock_out_select_o;
    boot_t boot_mode_o;
    int n_errors = 0;
    int n_tests = 0;

    clock_source_ctrl clock_source_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .fast_xtal_ok_i(fast_xtal_ok_i), .boot_select_pin_i(boot_select_pin_i),
        .user_option_byte_i(user_option_byte_i), .fast_xtal_en_o(fast_xtal_en_o),
        .fast_rc_en_o(fast_rc_en_o), .fast_osc_bypass_o(fast_osc_bypass_o),
        .slow_xtal_en_o(slow_xtal_en_o), .slow_rc_en_o(slow_rc_en_o),
        .slow_osc_bypass_o(slow_osc_bypass_o), .pll_en_o(pll_en_o),
        .pll_src_xtal_o(pll_src_xtal_o), .system_clock_sel_o(system_clock_sel_o),
        .clock_out_select_o(clock_out_select_o), .pll_out_div2_o(pll_out_div2_o),
        .boot_mode_o(boot_mode_o), .irq_o(irq_o), .nmi_o(nmi_o));

    // 100 ns period
    always #50 clk_i = ~clk_i;

    task automatic end_sim;
        if (n_errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // classic cycle; waits for ack as long as it takes, the watchdog ends a hang
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                      output logic [31:0] rd);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= 4'hf;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        check(wb_ack_o, 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] d;
        wb(1'b1, adr, dat, d);
        repeat (2) @(posedge clk_i);
    endtask

    task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] d;
        wb(1'b0, adr, 32'h0, d);
        check(d, exp);
    endtask

    // boot inputs settle before release, as the sync flops are not reset
    task automatic do_reset(input logic pin, input logic opt_n);
        @(posedge clk_i);
        rst_i <= 1'b1;
        boot_select_pin_i <= pin;
        user_option_byte_i <= {3'h0, opt_n, 4'h0};
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask

    task automatic t_reset;
        rdchk(OFS_CLOCK_CONTROL, 32'h0000_0102);
        check({fast_rc_en_o, fast_xtal_en_o, irq_o, nmi_o}, 4'h8);
        wr(8'h40, 32'hffff_ffff);
        rdchk(8'h40, 32'h0);
    endtask

    // pin/option table, then a change while running must not show
    task automatic t_boot;
        logic [1:0] pin_opt [4] = '{2'b00, 2'b11, 2'b10, 2'b01};
        boot_t exp [4] = '{BOOT_MAIN_FLASH, BOOT_SYSTEM_MEM, BOOT_SRAM, BOOT_MAIN_FLASH};
        for (int i = 0; i < 4; i++) begin
            do_reset(pin_opt[i][1], pin_opt[i][0]);
            check(boot_mode_o, exp[i]);
            rdchk(OFS_BOOT_STATUS, {30'h0, exp[i]});
            boot_select_pin_i <= ~pin_opt[i][1];
            user_option_byte_i <= {3'h0, ~pin_opt[i][0], 4'h0};
            repeat (8) @(posedge clk_i);
            check(boot_mode_o, exp[i]);
        end
        do_reset(1'b0, 1'b1);
    endtask

    task automatic t_outsel;
        for (int i = 0; i < 8; i++) begin
            wr(OFS_CLOCK_CONFIG, {28'h0, i == 7, i[2:0]});
            check(clock_out_select_o, i[2:0]);
            check(pll_out_div2_o, i == 7);
        end
    endtask

    task automatic t_src;
        wr(OFS_CLOCK_CONTROL, 32'h37);
        check({pll_src_xtal_o, pll_en_o, fast_osc_bypass_o, fast_xtal_en_o}, 4'hf);
        wr(OFS_CLOCK_CONTROL, 32'h13);
        check({pll_src_xtal_o, fast_osc_bypass_o}, 2'b00);
        // reserved system source code must leave the crystal selection alone
        wr(OFS_CLOCK_CONTROL, 32'h53);
        wr(OFS_CLOCK_CONTROL, 32'hd3);
        check(system_clock_sel_o, SYS_FAST_XTAL);
        wr(OFS_BACKUP_CTL, 32'h7);
        check({slow_rc_en_o, slow_osc_bypass_o, slow_xtal_en_o}, 3'h7);
        rdchk(OFS_BACKUP_CTL, 32'h7);
    endtask

    task automatic t_fault;
        // monitor off: a dead crystal is left alone
        wr(OFS_CLOCK_CONTROL, 32'h43);
        fast_xtal_ok_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        check({fast_xtal_en_o, nmi_o}, 2'b10);
        fast_xtal_ok_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        wr(OFS_IRQ_MASK, 32'h0);
        wr(OFS_CLOCK_CONTROL, 32'hbb);
        check(system_clock_sel_o, SYS_PLL);
        fast_xtal_ok_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        check(fast_xtal_en_o, 1'b0);
        check(pll_en_o, 1'b0);
        check(system_clock_sel_o, SYS_FAST_RC);
        check({fast_rc_en_o, nmi_o, irq_o}, 3'b110);
        rdchk(OFS_IRQ_STATUS, 32'h3);
        wr(OFS_IRQ_MASK, 32'h1);
        check(irq_o, 1'b1);
        wr(OFS_IRQ_STATUS, 32'h1);
        check({nmi_o, irq_o}, 2'b00);
        rdchk(OFS_IRQ_STATUS, 32'h2);
        wr(OFS_IRQ_STATUS, 32'h2);
        fast_xtal_ok_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        // crystal drives the system clock directly, pll untouched
        wr(OFS_CLOCK_CONTROL, 32'h4b);
        fast_xtal_ok_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        check({system_clock_sel_o, nmi_o}, {SYS_FAST_RC, 1'b1});
        rdchk(OFS_IRQ_STATUS, 32'h1);
    endtask

    // bounded by the expected run length with generous margin
    initial begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        end_sim();
    end

    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        t_reset();
        t_boot();
        t_outsel();
        t_src();
        t_fault();
        end_sim();
    end
endmodule // tb
`default_nettype wire
